// ### shared/srx_pkg.sv
// Package: register map, field positions and constants of the receive/baud block
package srx_pkg;

    // ******************************
    // Register map
    // ******************************
    localparam logic [7:0] SRX_ADDR_STATUS1 = 8'h42;
    localparam logic [7:0] SRX_ADDR_STATUS2 = 8'h43;
    localparam logic [7:0] SRX_ADDR_CTRL3 = 8'h44;
    localparam logic [7:0] SRX_ADDR_DATA = 8'h45;
    localparam logic [7:0] SRX_ADDR_BAUD = 8'h46;

    // ******************************
    // Field positions
    // ******************************
    // Status one
    localparam int SRX_S1_FULL = 5;
    localparam int SRX_S1_OVR = 3;
    localparam int SRX_S1_NOISE = 2;
    localparam int SRX_S1_FRAME = 1;
    localparam int SRX_S1_PAR = 0;
    // Status two
    localparam int SRX_S2_BREAK = 1;
    localparam int SRX_S2_RPF = 0;
    // Control three
    localparam int SRX_C3_NINTH = 7;
    localparam int SRX_C3_MODE9 = 6;
    localparam int SRX_C3_PAREN = 5;
    localparam int SRX_C3_PARODD = 4;
    localparam int SRX_C3_OVERRUN_IRQ_ENABLE = 3;
    localparam int SRX_C3_NOISE_IRQ_ENABLE = 2;
    localparam int SRX_C3_FRAMING_IRQ_ENABLE = 1;
    localparam int SRX_C3_PARITY_IRQ_ENABLE = 0;
    // Baud select
    localparam int SRX_BR_CKS = 6;
    localparam int SRX_BR_SCP_LO = 4;
    localparam int SRX_BR_SCR_LO = 0;

    // ******************************
    // Reset values and timing
    // ******************************
    localparam logic [6:0] SRX_CTRL3_RST = 7'h00;
    localparam logic [6:0] SRX_BAUD_RST = 7'h00;
    // Prescaler terminal counts, divisor minus one
    localparam logic [3:0] SRX_PRE1_LAST = 4'h0;
    localparam logic [3:0] SRX_PRE3_LAST = 4'h2;
    localparam logic [3:0] SRX_PRE4_LAST = 4'h3;
    localparam logic [3:0] SRX_PRE13_LAST = 4'hc;
    localparam logic [3:0] SRX_OVERSAMPLE = 4'hf;   // Last of 16 slots per bit
    localparam logic [3:0] SRX_VOTE_A = 4'h7;
    localparam logic [3:0] SRX_VOTE_B = 4'h8;
    localparam logic [3:0] SRX_VOTE_C = 4'h9;
    localparam logic [7:0] SRX_IDLE_SLOTS = 8'ha0;  // Ten bit times of ones
    localparam logic [3:0] SRX_BITS8 = 4'h8;
    localparam logic [3:0] SRX_BITS9 = 4'h9;

    // ******************************
    // Types
    // ******************************
    typedef enum logic [3:0] {
        SRX_IDLE = 4'b0001,
        SRX_START = 4'b0010,
        SRX_DATA = 4'b0100,
        SRX_STOP = 4'b1000
    } srx_state_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } srx_bus_s;

    typedef struct packed {
        logic [7:0] data;
        logic load;
    } srx_tx_s;

endpackage : srx_pkg

// ### src/srx_core.sv
// Serial receive status flags, shared data buffer and baud rate generator
`timescale 1ns/10ps
`default_nettype none

module srx_core (
    input wire logic clk,
    input wire logic nrst,
    input wire srx_pkg::srx_bus_s regBus,
    output logic [7:0] rdData,
    input wire logic rxdPin,
    input wire logic oscClkPin,
    output logic errIrq,
    output srx_pkg::srx_tx_s txWrite,
    output logic baudTick16
);
    import srx_pkg::*;

    // ******************************
    // Helpers
    // ******************************
    // Prescaler terminal count (divisor minus one)
    function automatic logic [3:0] prescaleLast(input logic [1:0] sel);
        unique case (sel)
            2'b00: prescaleLast = SRX_PRE1_LAST;
            2'b01: prescaleLast = SRX_PRE3_LAST;
            2'b10: prescaleLast = SRX_PRE4_LAST;
            2'b11: prescaleLast = SRX_PRE13_LAST;
        endcase
    endfunction : prescaleLast

    // Majority of three samples
    function automatic logic vote(input logic [2:0] s);
        vote = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : vote

    function automatic logic addrIs(input srx_bus_s b, input logic [7:0] a);
        addrIs = (b.addr == a);
    endfunction : addrIs

    // ******************************
    // Declarations
    // ******************************
    logic [1:0] rxSync_reg;
    logic [2:0] oscSync_reg;
    logic [6:0] ctrl3_reg;
    logic [6:0] baud_reg;
    logic [7:0] rxBuf_reg;
    logic ninth_reg;
    logic [3:0] preCnt_reg;
    logic [7:0] rateCnt_reg;
    logic srcTick;
    logic preTick;
    logic [7:0] rateLast;
    srx_state_e state_reg;
    logic [3:0] slot_reg;
    logic [3:0] bitCnt_reg;
    logic [2:0] samp_reg;
    logic [8:0] shift_reg;
    logic noiseAcc_reg;
    logic [7:0] idleCnt_reg;
    logic onesSeen_reg;
    logic fullFlag_reg, ovrFlag_reg, noiseFlag_reg, frameFlag_reg, parFlag_reg;
    logic breakFlag_reg, rpfFlag_reg;
    logic [4:0] arm1_reg;
    logic armBrk_reg;
    logic rxBit;
    logic done;
    logic [3:0] nBits;
    logic [8:0] word;
    logic parFail, stopZero, isBreak, dataRd, acceptNew;
    logic setFull, setOvr, setNoise, setFrame, setPar, setBreak;

    assign rxBit = rxSync_reg[1];
    assign dataRd = regBus.rd && addrIs(regBus, SRX_ADDR_DATA);

    // ******************************
    // Input synchronisers
    // ******************************
    // Line and oscillator pins come from outside the clock domain
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rxSync_reg <= 2'b11;
            oscSync_reg <= 3'b000;
        end else begin
            rxSync_reg <= {rxSync_reg[0], rxdPin};
            oscSync_reg <= {oscSync_reg[1:0], oscClkPin};
        end
    end

    // ******************************
    // Registers written by software
    // ******************************
    // select fields and control three; reset clears them
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl3_reg <= SRX_CTRL3_RST;
            baud_reg <= SRX_BAUD_RST;
        end else if (regBus.wr) begin
            if (addrIs(regBus, SRX_ADDR_CTRL3)) begin
                ctrl3_reg <= regBus.wdata[6:0];
            end
            if (addrIs(regBus, SRX_ADDR_BAUD)) begin
                // Unused bit three is never written, so it reads zero
                baud_reg[SRX_BR_CKS] <= regBus.wdata[SRX_BR_CKS];
                baud_reg[SRX_BR_SCP_LO +: 2] <= regBus.wdata[SRX_BR_SCP_LO +: 2];
                baud_reg[SRX_BR_SCR_LO +: 3] <= regBus.wdata[SRX_BR_SCR_LO +: 3];
            end
        end
    end

    // transmit byte handed on as a one-cycle load
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            txWrite <= '0;
        end else begin
            txWrite.load <= regBus.wr && addrIs(regBus, SRX_ADDR_DATA);
            if (regBus.wr && addrIs(regBus, SRX_ADDR_DATA)) begin
                txWrite.data <= regBus.wdata;
            end
        end
    end

    // ******************************
    // Baud generator
    // ******************************
    // source select: oscillator rising edge or every bus cycle
    assign srcTick = baud_reg[SRX_BR_CKS] ? 1'b1 : (oscSync_reg[1] & ~oscSync_reg[2]);
    assign preTick = srcTick && (preCnt_reg == prescaleLast(baud_reg[SRX_BR_SCP_LO +: 2]));
    assign rateLast = 8'((9'h001 << baud_reg[SRX_BR_SCR_LO +: 3]) - 9'h001);

    // divide chain gives sixteen ticks per bit
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            preCnt_reg <= 4'h0;
            rateCnt_reg <= 8'h00;
            baudTick16 <= 1'b0;
        end else begin
            baudTick16 <= 1'b0;
            if (srcTick) begin
                preCnt_reg <= preTick ? 4'h0 : preCnt_reg + 4'h1;
            end
            if (preTick) begin
                if (rateCnt_reg >= rateLast) begin
                    rateCnt_reg <= 8'h00;
                    baudTick16 <= 1'b1;
                end else begin
                    rateCnt_reg <= rateCnt_reg + 8'h01;
                end
            end
        end
    end

    // ******************************
    // Receive shifter
    // ******************************
    assign nBits = ctrl3_reg[SRX_C3_MODE9] ? SRX_BITS9 : SRX_BITS8;
    assign done = baudTick16 && (state_reg == SRX_STOP) && (slot_reg == SRX_VOTE_C);
    assign word = ctrl3_reg[SRX_C3_MODE9] ? shift_reg : {1'b0, shift_reg[8:1]};
    assign stopZero = !vote({samp_reg[1:0], rxBit});
    assign isBreak = stopZero && (word == 9'h000);
    // Parity covers the whole received word; last bit is the parity bit
    assign parFail = ctrl3_reg[SRX_C3_PAREN]
        && ((^word) != ctrl3_reg[SRX_C3_PARODD]);

    // Frame sequencing at sixteen samples per bit
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= SRX_IDLE;
            slot_reg <= 4'h0;
            bitCnt_reg <= 4'h0;
            samp_reg <= 3'b111;
            shift_reg <= 9'h000;
            noiseAcc_reg <= 1'b0;
        end else if (baudTick16) begin
            slot_reg <= slot_reg + 4'h1;
            if (slot_reg == SRX_VOTE_A) samp_reg[0] <= rxBit;
            if (slot_reg == SRX_VOTE_B) samp_reg[1] <= rxBit;
            unique case (state_reg)
                SRX_IDLE: begin
                    // low seen at first start sample
                    if (!rxBit) begin
                        state_reg <= SRX_START;
                        slot_reg <= 4'h1;
                        noiseAcc_reg <= 1'b0;
                    end else begin
                        slot_reg <= 4'h0;
                    end
                end
                SRX_START: begin
                    if (slot_reg == SRX_VOTE_C) begin
                        if (vote({samp_reg[1:0], rxBit})) begin
                            state_reg <= SRX_IDLE;
                            slot_reg <= 4'h0;
                        end
                        if (samp_reg[1:0] != {2{rxBit}}) noiseAcc_reg <= 1'b1;
                    end
                    if (slot_reg == SRX_OVERSAMPLE) begin
                        state_reg <= SRX_DATA;
                        bitCnt_reg <= 4'h0;
                    end
                end
                SRX_DATA: begin
                    if (slot_reg == SRX_VOTE_C) begin
                        shift_reg <= {vote({samp_reg[1:0], rxBit}), shift_reg[8:1]};
                        if (samp_reg[1:0] != {2{rxBit}}) noiseAcc_reg <= 1'b1;
                        bitCnt_reg <= bitCnt_reg + 4'h1;
                    end
                    if (slot_reg == SRX_OVERSAMPLE && bitCnt_reg == nBits) begin
                        state_reg <= SRX_STOP;
                    end
                end
                SRX_STOP: begin
                    if (slot_reg == SRX_VOTE_C) begin
                        // Early return lets the next start bit be caught
                        state_reg <= SRX_IDLE;
                        slot_reg <= 4'h0;
                    end
                end
            endcase
        end
    end

    // ******************************
    // Idle line and break rearm
    // ******************************
    // Counts high samples while idle; ones must reappear after a break
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            idleCnt_reg <= 8'h00;
            onesSeen_reg <= 1'b1;
        end else begin
            if (baudTick16) begin
                if (!rxBit || state_reg != SRX_IDLE) begin
                    idleCnt_reg <= 8'h00;
                end else if (idleCnt_reg != SRX_IDLE_SLOTS) begin
                    idleCnt_reg <= idleCnt_reg + 8'h01;
                end
            end
            if (done && isBreak) begin
                onesSeen_reg <= 1'b0;
            end else if (baudTick16 && rxBit) begin
                onesSeen_reg <= 1'b1;
            end
        end
    end

    // ******************************
    // Completion events
    // ******************************
    // a character is accepted only into an empty buffer
    assign acceptNew = done && !fullFlag_reg;
    assign setFull = acceptNew;
    assign setOvr = done && fullFlag_reg;
    assign setNoise = acceptNew && noiseAcc_reg;
    assign setFrame = acceptNew && stopZero;
    assign setPar = acceptNew && parFail;
    // break only when rearmed by ones
    assign setBreak = acceptNew && isBreak && onesSeen_reg;

    // buffer holds across reset on purpose; no reset branch
    always_ff @(posedge clk) begin
        if (acceptNew) begin
            rxBuf_reg <= word[7:0];
            // break clears the ninth bit in 9-bit mode
            ninth_reg <= ctrl3_reg[SRX_C3_MODE9] ? (word[8] && !isBreak) : word[7];
        end
    end

    // ******************************
    // Flag clearing sequence
    // ******************************
    // arm only flags seen set by the status read
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            arm1_reg <= 5'b00000;
            armBrk_reg <= 1'b0;
        end else begin
            if (dataRd) begin
                arm1_reg <= 5'b00000;
                armBrk_reg <= 1'b0;
            end
            if (regBus.rd && addrIs(regBus, SRX_ADDR_STATUS1)) begin
                arm1_reg <= {fullFlag_reg, ovrFlag_reg, noiseFlag_reg,
                    frameFlag_reg, parFlag_reg};
            end
            if (regBus.rd && addrIs(regBus, SRX_ADDR_STATUS2)) begin
                armBrk_reg <= breakFlag_reg;
            end
        end
    end

    // reset clears all sticky flags; a set wins over a clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fullFlag_reg <= 1'b0;
            ovrFlag_reg <= 1'b0;
            noiseFlag_reg <= 1'b0;
            frameFlag_reg <= 1'b0;
            parFlag_reg <= 1'b0;
            breakFlag_reg <= 1'b0;
        end else begin
            // clear on data read after arming
            fullFlag_reg <= setFull | (fullFlag_reg & ~(dataRd & arm1_reg[4]));
            ovrFlag_reg <= setOvr | (ovrFlag_reg & ~(dataRd & arm1_reg[3]));
            noiseFlag_reg <= setNoise | (noiseFlag_reg & ~(dataRd & arm1_reg[2]));
            frameFlag_reg <= setFrame | (frameFlag_reg & ~(dataRd & arm1_reg[1]));
            parFlag_reg <= setPar | (parFlag_reg & ~(dataRd & arm1_reg[0]));
            breakFlag_reg <= setBreak | (breakFlag_reg & ~(dataRd & armBrk_reg));
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rpfFlag_reg <= 1'b0;
        end else if (baudTick16) begin
            if (state_reg == SRX_IDLE && !rxBit) begin
                rpfFlag_reg <= 1'b1;
            end else if (state_reg == SRX_START && slot_reg == SRX_VOTE_C
                    && vote({samp_reg[1:0], rxBit})) begin
                rpfFlag_reg <= 1'b0;
            end else if (idleCnt_reg == SRX_IDLE_SLOTS) begin
                rpfFlag_reg <= 1'b0;
            end
        end
    end

    // ******************************
    // Error request and read port
    // ******************************
    // gated error request; break and progress excluded
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            errIrq <= 1'b0;
        end else begin
            errIrq <= (ovrFlag_reg & ctrl3_reg[SRX_C3_OVERRUN_IRQ_ENABLE])
                | (noiseFlag_reg & ctrl3_reg[SRX_C3_NOISE_IRQ_ENABLE])
                | (frameFlag_reg & ctrl3_reg[SRX_C3_FRAMING_IRQ_ENABLE])
                | (parFlag_reg & ctrl3_reg[SRX_C3_PARITY_IRQ_ENABLE]);
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdData <= 8'h00;
        end else begin
            rdData <= 8'h00;
            if (regBus.rd) begin
                unique case (regBus.addr)
                    SRX_ADDR_STATUS1: begin
                        rdData[SRX_S1_FULL] <= fullFlag_reg;
                        rdData[SRX_S1_OVR] <= ovrFlag_reg;
                        rdData[SRX_S1_NOISE] <= noiseFlag_reg;
                        rdData[SRX_S1_FRAME] <= frameFlag_reg;
                        rdData[SRX_S1_PAR] <= parFlag_reg;
                    end
                    SRX_ADDR_STATUS2: begin
                        rdData[SRX_S2_BREAK] <= breakFlag_reg;
                        rdData[SRX_S2_RPF] <= rpfFlag_reg;
                    end
                    SRX_ADDR_CTRL3: rdData <= {ninth_reg, ctrl3_reg};
                    // received byte on the shared address
                    SRX_ADDR_DATA: rdData <= rxBuf_reg;
                    SRX_ADDR_BAUD: rdData <= {1'b0, baud_reg};
                    default: rdData <= 8'h00;
                endcase
            end
        end
    end

endmodule : srx_core
`default_nettype wire

// ### bench/srx_core_sva.sv
// Checker: port-level assertions for the receive and baud block
`timescale 1ns/10ps
`default_nettype none

module srx_core_sva (
    input wire logic clk,
    input wire logic nrst,
    input wire srx_pkg::srx_bus_s regBus,
    input wire logic [7:0] rdData,
    input wire logic rxdPin,
    input wire logic oscClkPin,
    input wire logic errIrq,
    input wire srx_pkg::srx_tx_s txWrite,
    input wire logic baudTick16
);
    import srx_pkg::*;

    // **********************
    // Shadow state
    // **********************
    logic [6:0] baud_reg;
    logic [6:0] ctl_reg;
    logic [10:0] gap_reg;
    logic [1:0] seen_reg;
    logic [10:0] divVal;

    // Prescaler times rate divisor, bus clock source only
    assign divVal = (baud_reg[5:4] == 2'h0 ? 11'h001 : baud_reg[5:4] == 2'h1 ? 11'h003 :
        baud_reg[5:4] == 2'h2 ? 11'h004 : 11'h00d) << baud_reg[2:0];

    // Writable registers mirrored from the bus
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            baud_reg <= 7'h00;
            ctl_reg <= 7'h00;
        end else if (regBus.wr && regBus.addr == SRX_ADDR_BAUD) begin
            baud_reg <= regBus.wdata[6:0];
        end else if (regBus.wr && regBus.addr == SRX_ADDR_CTRL3) begin
            ctl_reg <= regBus.wdata[6:0];
        end
    end

    // Tick spacing; two ticks after a change let the divider phase settle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gap_reg <= 11'h000;
            seen_reg <= 2'h0;
        end else if (regBus.wr && regBus.addr == SRX_ADDR_BAUD) begin
            gap_reg <= 11'h000;
            seen_reg <= 2'h0;
        end else if (baudTick16) begin
            gap_reg <= 11'h000;
            seen_reg <= (seen_reg == 2'h2) ? 2'h2 : seen_reg + 2'h1;
        end else begin
            gap_reg <= gap_reg + 11'h001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_RD_IDLE: assert property (!$past(regBus.rd) |-> rdData == 8'h00)
        else $error("read data not zero outside read answer");
    AST_TX_LOAD: assert property (regBus.wr && regBus.addr == SRX_ADDR_DATA |=>
        txWrite.load && txWrite.data == $past(regBus.wdata))
        else $error("transmit byte not loaded");
    AST_TX_QUIET: assert property (!(regBus.wr && regBus.addr == SRX_ADDR_DATA) |=>
        !txWrite.load)
        else $error("transmit load without write");
    AST_UNMAPPED: assert property (regBus.rd && (regBus.addr < SRX_ADDR_STATUS1 ||
        regBus.addr > SRX_ADDR_BAUD) |=> rdData == 8'h00)
        else $error("unmapped read not zero");
    AST_BAUD_RD: assert property (regBus.rd && regBus.addr == SRX_ADDR_BAUD |=>
        rdData == {1'b0, baud_reg[6:4], 1'b0, baud_reg[2:0]})
        else $error("baud register readback wrong");
    AST_CTRL_RD: assert property (regBus.rd && regBus.addr == SRX_ADDR_CTRL3 |=>
        rdData[6:0] == ctl_reg)
        else $error("control readback wrong");
    AST_IRQ_GATE: assert property (ctl_reg[3:0] == 4'h0 && $past(ctl_reg[3:0]) == 4'h0
        |-> !errIrq)
        else $error("error request with all enables clear");
    AST_TICK_GAP: assert property (baud_reg[6] && seen_reg == 2'h2 && baudTick16 |->
        gap_reg == divVal - 11'h001)
        else $error("tick spacing differs from divisor");
endmodule : srx_core_sva

bind srx_core srx_core_sva i_sva (.clk(clk), .nrst(nrst), .regBus(regBus),
    .rdData(rdData), .rxdPin(rxdPin), .oscClkPin(oscClkPin), .errIrq(errIrq),
    .txWrite(txWrite), .baudTick16(baudTick16));

`default_nettype wire

// ### bench/srx_serial_tx.sv
// Remote serial transmitter model driving the receive line
`timescale 1ns/10ps
`default_nettype none

module srx_serial_tx (
    input wire logic clk,
    input wire logic baudTick16,
    output logic rxdPin
);
    // **********************
    // Line driver
    // **********************
    initial rxdPin = 1'b1;

    // Hold a level for n ticks of the shared rate
    task automatic hold(input logic lvl, input int n);
        repeat (n) begin
            @(posedge clk iff baudTick16);
            rxdPin <= lvl;
        end
    endtask : hold

    // start, data LSB first, chosen stop level
    task automatic send(input logic [8:0] w, input int nbits, input logic stp, input logic noisy);
        logic v;
        for (int b = 0; b < nbits + 2; b++) begin
            v = (b == 0) ? 1'b0 : (b <= nbits) ? w[b-1] : stp;
            if (noisy && b == 1) begin
                hold(v, 8);
                hold(~v, 1);
                hold(v, 7);
            end else begin
                hold(v, 16);
            end
        end
        // ones back on the line after every frame
        hold(1'b1, 3);
    endtask : send
endmodule : srx_serial_tx

`default_nettype wire

// ### bench/srx_core_tb.sv
// Testbench: register-level tests of the receive and baud block
`timescale 1ns/10ps
`default_nettype none

module srx_core_tb;
    import srx_pkg::*;

    logic clk, nrst, rxdPin, oscClkPin, errIrq, baudTick16;
    logic [7:0] rdData, rv;
    srx_bus_s regBus;
    srx_tx_s txWrite;
    int num_errors, checks;
    int pdTab[4] = '{1, 3, 4, 13};

    srx_core i_dut (.clk(clk), .nrst(nrst), .regBus(regBus), .rdData(rdData), .rxdPin(rxdPin),
        .oscClkPin(oscClkPin), .errIrq(errIrq), .txWrite(txWrite), .baudTick16(baudTick16));
    srx_serial_tx i_tx (.clk(clk), .baudTick16(baudTick16), .rxdPin(rxdPin));

    // **********************
    // Clocks and bus tasks
    // **********************
    initial clk = 1'b0;
    always #4 clk = ~clk;
    // Oscillator source, five bus clocks per period; offset so no edge meets a clk edge
    initial begin
        oscClkPin = 1'b0;
        #2;
        forever #20 oscClkPin = ~oscClkPin;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regBus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        regBus <= '0;
    endtask : wr

    // Answer stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regBus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        regBus <= '0;
        #1 rv = rdData;
    endtask : rd

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Clocks between ticks; first two intervals skipped as phase is unknown
    task automatic gap(input int exp);
        int n;
        n = 0;
        repeat (2) @(posedge clk iff baudTick16);
        do begin
            @(posedge clk);
            n++;
        end while (baudTick16 !== 1'b1 && n < 4000);
        chk(16'(n), 16'(exp));
    endtask : gap

    task automatic complete_run();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        #400000;
        num_errors++;
        complete_run();
    end

    // **********************
    // Test sequence
    // **********************
    initial begin
        regBus = '0;
        nrst = 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd(SRX_ADDR_BAUD);
        chk(rv, 8'h00);
        rd(SRX_ADDR_CTRL3);
        chk(rv & 8'h7f, 8'h00);
        rd(SRX_ADDR_STATUS1);
        chk(rv, 8'h00);
        gap(5);
        for (int p = 0; p < 4; p++) begin
            for (int r = 0; r < 8; r += 7) begin
                wr(SRX_ADDR_BAUD, {2'b01, 2'(p), 1'b0, 3'(r)});
                rd(SRX_ADDR_BAUD);
                chk(rv, {2'b01, 2'(p), 1'b0, 3'(r)});
                gap(pdTab[p] << r);
            end
        end
        wr(SRX_ADDR_BAUD, 8'h41);
        wr(SRX_ADDR_CTRL3, 8'h08);
        i_tx.send(9'h0a5, 8, 1'b1, 1'b0);
        rd(SRX_ADDR_STATUS1);
        chk(rv, 8'h20);
        chk(errIrq, 1'b0);
        rd(SRX_ADDR_CTRL3);
        chk(rv, 8'h88);
        i_tx.send(9'h03c, 8, 1'b1, 1'b0);
        rd(SRX_ADDR_STATUS1);
        chk(rv, 8'h28);
        chk(errIrq, 1'b1);
        rd(SRX_ADDR_DATA);
        chk(rv, 8'ha5);
        rd(SRX_ADDR_STATUS1);
        chk(rv, 8'h00);
        i_tx.send(9'h011, 8, 1'b1, 1'b0);
        rd(SRX_ADDR_STATUS1);
        i_tx.send(9'h022, 8, 1'b1, 1'b0);
        rd(SRX_ADDR_DATA);
        chk(rv, 8'h11);
        rd(SRX_ADDR_STATUS1);
        chk(rv, 8'h08);
        rd(SRX_ADDR_DATA);
        rd(SRX_ADDR_STATUS1);
        chk(rv, 8'h00);
        wr(SRX_ADDR_CTRL3, 8'h00);
        i_tx.send(9'h05a, 8, 1'b0, 1'b0);
        rd(SRX_ADDR_STATUS1);
        chk(rv, 8'h22);
        chk(errIrq, 1'b0);
        wr(SRX_ADDR_CTRL3, 8'h02);
        repeat (2) @(posedge clk);
        chk(errIrq, 1'b1);
        rd(SRX_ADDR_STATUS1);
        rd(SRX_ADDR_DATA);
        chk(rv, 8'h5a);
        rd(SRX_ADDR_STATUS1);
        chk(rv, 8'h00);
        wr(SRX_ADDR_CTRL3, 8'h04);
        i_tx.send(9'h0f0, 8, 1'b1, 1'b1);
        rd(SRX_ADDR_STATUS1);
        chk(rv, 8'h24);
        chk(errIrq, 1'b1);
        rd(SRX_ADDR_DATA);
        chk(rv, 8'hf0);
        rd(SRX_ADDR_STATUS1);
        chk(rv, 8'h00);
        wr(SRX_ADDR_CTRL3, 8'h21);
        i_tx.send(9'h001, 8, 1'b1, 1'b0);
        rd(SRX_ADDR_STATUS1);
        chk(rv, 8'h21);
        chk(errIrq, 1'b1);
        rd(SRX_ADDR_DATA);
        i_tx.send(9'h081, 8, 1'b1, 1'b0);
        rd(SRX_ADDR_STATUS1);
        chk(rv, 8'h20);
        rd(SRX_ADDR_DATA);
        wr(SRX_ADDR_CTRL3, 8'h70);
        i_tx.send(9'h100, 9, 1'b1, 1'b0);
        rd(SRX_ADDR_STATUS1);
        chk(rv, 8'h20);
        rd(SRX_ADDR_CTRL3);
        chk(rv, 8'hf0);
        rd(SRX_ADDR_STATUS2);
        chk(rv, 8'h01);
        i_tx.hold(1'b1, 170);
        rd(SRX_ADDR_STATUS2);
        chk(rv, 8'h00);
        rd(SRX_ADDR_DATA);
        chk(rv, 8'h00);
        wr(SRX_ADDR_CTRL3, 8'h40);
        i_tx.send(9'h000, 9, 1'b0, 1'b0);
        rd(SRX_ADDR_STATUS1);
        chk(rv, 8'h22);
        rd(SRX_ADDR_CTRL3);
        chk(rv, 8'h40);
        chk(errIrq, 1'b0);
        rd(SRX_ADDR_DATA);
        rd(SRX_ADDR_STATUS2);
        chk(rv & 8'h02, 8'h02);
        rd(SRX_ADDR_DATA);
        rd(SRX_ADDR_STATUS2);
        chk(rv & 8'h02, 8'h00);
        i_tx.hold(1'b0, 4);
        rd(SRX_ADDR_STATUS2);
        chk(rv, 8'h01);
        i_tx.hold(1'b1, 20);
        rd(SRX_ADDR_STATUS2);
        chk(rv, 8'h00);
        // data register only written whole, never read back and modified
        wr(SRX_ADDR_DATA, 8'h96);
        #1 chk({txWrite.load, txWrite.data}, 16'h0196);
        rd(SRX_ADDR_DATA);
        chk(rv, 8'h00);
        rd(8'h47);
        chk(rv, 8'h00);
        wr(SRX_ADDR_CTRL3, 8'h00);
        i_tx.send(9'h077, 8, 1'b0, 1'b0);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd(SRX_ADDR_STATUS1);
        chk(rv, 8'h00);
        rd(SRX_ADDR_STATUS2);
        chk(rv, 8'h00);
        rd(SRX_ADDR_DATA);
        chk(rv, 8'h77);
        complete_run();
    end
endmodule : srx_core_tb

`default_nettype wire
